// ==== igc_regs.sv ====
// Input gain control register bank with per-amplifier gain ramps.
// Assumes a decoded register port from the control interface engine.

////////////////////////////////////////////////////////////////////////////////
module igc_regs #(
	parameter int STEP_CYC0 = igc_pkg::STEP_CYC0,
	parameter int STEP_CYC1 = igc_pkg::STEP_CYC1,
	parameter int STEP_CYC2 = igc_pkg::STEP_CYC2
) (
	// Clock and reset
	input wire logic SYS_CLK,
	input wire logic RST,
	// Register port
	input wire logic [7:0] REG_ADDR,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [7:0] REG_WDATA,
	output logic [7:0] REG_RDATA,
	output logic REG_ACK,
	// Amplifier drive
	output logic [3:0] AMP_POWER_UP,
	output logic [3:0] AMP_MUTE,
	output logic [3:0] AMP_RAMPING,
	output logic [3:0] AMP_EXTRA_GAIN,
	output logic [3:0][5:0] AMP_GAIN_CODE,
	output logic [3:0][8:0] AMP_GAIN_QDB,
	// Click guard disables
	output logic [3:0] AMP_CLICK_GUARD_OFF,
	output logic HEADPHONE0_CLICK_GUARD_OFF,
	output logic HEADPHONE1_CLICK_GUARD_OFF
);

	typedef struct packed {
		logic [3:0][7:0] amp;
		logic [7:0] slew;
		logic [7:0] boost;
		logic [7:0] pop;
		logic [7:0] rdata;
		logic ack;
	} igc_regs_s;

	igc_regs_s r, n;
	logic hit;
	logic [7:0] rd_val;
	logic tick;

	////////////////////////////////////////////////////////////////////////////
	// Address decode

	always_comb begin
		hit = 1'b1;
		rd_val = 8'h00;
		if (REG_ADDR >= igc_pkg::ADDR_AMP0 && REG_ADDR <= igc_pkg::ADDR_AMP3) begin
			rd_val = r.amp[2'(REG_ADDR - igc_pkg::ADDR_AMP0)]; // R11
		end else if (REG_ADDR == igc_pkg::ADDR_SLEW) begin
			rd_val = r.slew; // R7
		end else if (REG_ADDR == igc_pkg::ADDR_BOOST) begin
			rd_val = r.boost; // R8
		end else if (REG_ADDR == igc_pkg::ADDR_POP) begin
			rd_val = r.pop; // R9
		end else begin
			hit = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Register state

	always_comb begin
		n = r;
		n.ack = (REG_WR | REG_RD) & hit;
		if (REG_RD) begin
			n.rdata = rd_val;
		end
		if (REG_WR) begin
			if (REG_ADDR >= igc_pkg::ADDR_AMP0 && REG_ADDR <= igc_pkg::ADDR_AMP3) begin
				n.amp[2'(REG_ADDR - igc_pkg::ADDR_AMP0)] =
					REG_WDATA & igc_pkg::MASK_AMP; // R4 R11
			end else if (REG_ADDR == igc_pkg::ADDR_SLEW) begin
				n.slew = REG_WDATA & igc_pkg::MASK_SLEW; // R12
			end else if (REG_ADDR == igc_pkg::ADDR_BOOST) begin
				n.boost = REG_WDATA & igc_pkg::MASK_BOOST; // R12
			end else if (REG_ADDR == igc_pkg::ADDR_POP) begin
				n.pop = REG_WDATA & igc_pkg::MASK_POP; // R12
			end
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			r.amp <= {4{igc_pkg::RST_AMP}}; // R4 R11
			r.slew <= igc_pkg::RST_SLEW; // R7
			r.boost <= igc_pkg::RST_BOOST; // R8
			r.pop <= igc_pkg::RST_POP; // R9
			r.rdata <= 8'h00;
			r.ack <= 1'b0;
		end else begin
			r <= n;
		end
	end

	assign REG_RDATA = r.rdata;
	assign REG_ACK = r.ack;

	////////////////////////////////////////////////////////////////////////////
	// Gain ramps

	// One shared timer: steps of all amps stay aligned, saving three counters
	igc_step_timer #(
		.CYC0(STEP_CYC0),
		.CYC1(STEP_CYC1),
		.CYC2(STEP_CYC2)
	) u_timer (
		.clk(SYS_CLK),
		.rst(RST),
		.rate(r.slew[igc_pkg::RATE_LSB +: igc_pkg::RATE_W]), // R5
		.tick(tick)
	);

	for (genvar i = 0; i < igc_pkg::NUM_AMPS; i++) begin : g_amp
		logic signed [8:0] qdb;
		igc_gain_ramp u_ramp (
			.clk(SYS_CLK),
			.rst(RST),
			.mic_sel(r.amp[i][igc_pkg::AMP_SEL_BIT]), // R1
			.mute(r.amp[i][igc_pkg::AMP_MUTE_BIT]), // R2
			.code(r.amp[i][igc_pkg::GAIN_LSB +: igc_pkg::GAIN_W]), // R3
			.boost(r.boost[i]), // R8
			.slew_off(r.slew[i]), // R6
			.tick(tick),
			.power(AMP_POWER_UP[i]),
			.muted(AMP_MUTE[i]),
			.ramping(AMP_RAMPING[i]),
			.gain(AMP_GAIN_CODE[i]),
			.gain_qdb(qdb)
		);
		assign AMP_GAIN_QDB[i] = qdb;
	end

	assign AMP_EXTRA_GAIN = r.boost[3:0]; // R8
	assign AMP_CLICK_GUARD_OFF = r.pop[3:0]; // R10
	assign HEADPHONE0_CLICK_GUARD_OFF = r.pop[igc_pkg::HP_GUARD_LSB]; // R9
	assign HEADPHONE1_CLICK_GUARD_OFF = r.pop[igc_pkg::HP_GUARD_LSB + 1]; // R9

	////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (RST);

	logic past_rst;
	always_ff @(posedge SYS_CLK) begin
		past_rst <= RST;
	end

	amp3_reset_a: assert property (past_rst |-> r.amp[3] == 8'h40 && // R4
		AMP_MUTE[3] == 1'b1 && AMP_POWER_UP[3] == 1'b0)
		else $error("amp 3 control not at reset value");

	slew_reset_a: assert property (past_rst |-> r.slew == 8'h00 && // R7
		r.boost == 8'h00)
		else $error("slew or boost register not at reset value");

	pop_reset_a: assert property (past_rst |-> // R9
		{HEADPHONE1_CLICK_GUARD_OFF, HEADPHONE0_CLICK_GUARD_OFF,
		AMP_CLICK_GUARD_OFF} == 6'h3f)
		else $error("click guard disables not all set after reset");

	reserved_zero_a: assert property (r.slew[7:6] == 2'b00 && // R12
		r.boost[7:4] == 4'h0 && r.pop[7:6] == 2'b00)
		else $error("reserved bit not zero");

	power_follow_a: assert property ( // R1
		r.amp[3][7] && !AMP_POWER_UP[3] |=> AMP_POWER_UP[3])
		else $error("amp 3 not powered after mic select");

	power_off_a: assert property ( // R1
		!r.amp[3][7] |=> !AMP_POWER_UP[3] && AMP_GAIN_CODE[3] == 6'h00)
		else $error("amp 3 not powered down in line mode");

	mute_freeze_a: assert property ( // R2
		AMP_POWER_UP[3] && r.amp[3][6] && $stable(r.amp[3][7]) &&
		$past(r.amp[3][6]) |=> $stable(AMP_GAIN_CODE[3]))
		else $error("muted amp 3 gain moved");

	slew_off_a: assert property ( // R6
		AMP_POWER_UP[0] && r.amp[0][7] && r.slew[0] && !r.amp[0][6] |=>
		AMP_GAIN_CODE[0] == $past(r.amp[0][5:0]))
		else $error("slew disabled amp 0 did not jump to code");

	ramp_step_a: assert property ( // R5
		AMP_POWER_UP[2] && r.amp[2][7] && !r.slew[2] && !tick |=>
		$stable(AMP_GAIN_CODE[2]))
		else $error("amp 2 gain moved without a step tick");

	gain_map_a: assert property ( // R3
		!r.boost[1] && $stable(r.boost[1]) && AMP_GAIN_CODE[1] == 6'h10 |->
		AMP_GAIN_QDB[1] == 9'h000)
		else $error("code 0x10 does not map to 0 dB");

	boost_add_a: assert property ( // R8
		r.boost[3] && $stable(r.boost[3]) |->
		$signed(AMP_GAIN_QDB[3]) == $signed(9'(-48 + 40)) +
		$signed(9'(3 * int'(AMP_GAIN_CODE[3]))))
		else $error("amp 3 boost not 10 dB");

	read_back_a: assert property ( // R11
		REG_RD && REG_ADDR == 8'h24 |=> REG_ACK && REG_RDATA == $past(r.amp[1]))
		else $error("amp 1 control read back wrong");

	write_guard_a: assert property ( // R10
		REG_WR && REG_ADDR == 8'h29 |=>
		AMP_CLICK_GUARD_OFF == $past(REG_WDATA[3:0]))
		else $error("click guard write not applied");

	amp_low_reset_a: assert property (past_rst |-> // R11
		r.amp[0] == 8'h40 && r.amp[1] == 8'h40 && r.amp[2] == 8'h40 &&
		AMP_POWER_UP[2:0] == 3'b000 && AMP_MUTE[2:0] == 3'b111)
		else $error("amps 0 to 2 not at reset value");

	qdb_reset_a: assert property (past_rst |-> // R3
		AMP_GAIN_QDB == {4{9'h1d0}} && AMP_GAIN_CODE == '0)
		else $error("applied gain not at code zero after reset");

	ack_map_a: assert property ( // R11
		(REG_WR || REG_RD) && REG_ADDR >= 8'h23 && REG_ADDR <= 8'h29 |=>
		REG_ACK)
		else $error("mapped access not acknowledged");

	// No ack off the map, so a bad address shows up as a timeout
	miss_quiet_a: assert property ( // R11
		(REG_WR || REG_RD) && (REG_ADDR < 8'h23 || REG_ADDR > 8'h29) |=>
		!REG_ACK)
		else $error("unmapped access acknowledged");

	idle_no_ack_a: assert property ( // R11
		!REG_WR && !REG_RD |=> !REG_ACK)
		else $error("ack without a request");

	miss_read_a: assert property ( // R11
		REG_RD && REG_ADDR > 8'h29 |=> REG_RDATA == 8'h00)
		else $error("unmapped read not zero");

	rdata_hold_a: assert property ( // R11
		!REG_RD |=> $stable(REG_RDATA))
		else $error("read data moved without a read");

	amp3_write_a: assert property ( // R4
		REG_WR && REG_ADDR == 8'h26 |=> r.amp[3] == $past(REG_WDATA))
		else $error("amp 3 control write not applied");

	slew_write_a: assert property ( // R12
		REG_WR && REG_ADDR == 8'h27 |=>
		r.slew == {2'b00, $past(REG_WDATA[5:0])})
		else $error("slew register write wrong");

	boost_write_a: assert property ( // R8
		REG_WR && REG_ADDR == 8'h28 |=>
		AMP_EXTRA_GAIN == $past(REG_WDATA[3:0]))
		else $error("boost write not applied");

	hp_write_a: assert property ( // R9
		REG_WR && REG_ADDR == 8'h29 |=> $past(REG_WDATA[5:4]) ==
		{HEADPHONE1_CLICK_GUARD_OFF, HEADPHONE0_CLICK_GUARD_OFF})
		else $error("headphone guard write not applied");

	guard_hold_a: assert property ( // R10
		!(REG_WR && REG_ADDR == 8'h29) |=> $stable(AMP_CLICK_GUARD_OFF))
		else $error("click guard moved without a write");

	read_slew_a: assert property ( // R7
		REG_RD && REG_ADDR == 8'h27 |=> REG_RDATA == $past(r.slew))
		else $error("slew register read back wrong");

	read_amp3_a: assert property ( // R4
		REG_RD && REG_ADDR == 8'h26 |=> REG_RDATA == $past(r.amp[3]))
		else $error("amp 3 control read back wrong");

	read_pop_a: assert property ( // R9
		REG_RD && REG_ADDR == 8'h29 |=> REG_RDATA == $past(r.pop))
		else $error("charge register read back wrong");

	mute_copy_a: assert property ( // R2
		1'b1 |=> AMP_MUTE[3] == $past(r.amp[3][6]))
		else $error("amp 3 mute not following its bit");

	step_up_a: assert property ( // R5
		AMP_RAMPING[0] && r.amp[0][7] && !r.amp[0][6] && !r.slew[0] &&
		tick && AMP_GAIN_CODE[0] < r.amp[0][5:0] |=>
		AMP_GAIN_CODE[0] == $past(AMP_GAIN_CODE[0]) + 6'h01)
		else $error("amp 0 ramp step not one code up");

	slew_ignore_a: assert property ( // R6
		AMP_POWER_UP[1] && r.amp[1][7] && r.slew[1] |=> !AMP_RAMPING[1])
		else $error("slew disabled amp 1 still ramping");

	amp1_power_a: assert property ( // R11
		r.amp[1][7] && !AMP_POWER_UP[1] |=>
		AMP_POWER_UP[1] && AMP_GAIN_CODE[1] == 6'h00)
		else $error("amp 1 not powered from code zero");

	amp0_off_a: assert property ( // R11
		!r.amp[0][7] |=> !AMP_POWER_UP[0] && AMP_GAIN_CODE[0] == 6'h00)
		else $error("amp 0 not powered down in line mode");

	boost_none_a: assert property ( // R8
		!r.boost[0] && $stable(r.boost[0]) |->
		$signed(AMP_GAIN_QDB[0]) == $signed(9'(-48)) +
		$signed(9'(3 * int'(AMP_GAIN_CODE[0]))))
		else $error("amp 0 gain wrong without boost");

	mic_up_c: cover property (AMP_POWER_UP[3] && !AMP_MUTE[3] && AMP_RAMPING[3]);
	mute_hold_c: cover property (AMP_MUTE[3] && AMP_POWER_UP[3]);
	boost_c: cover property (AMP_EXTRA_GAIN[0] && AMP_POWER_UP[0]);
	slew_long_c: cover property (r.slew[5:4] == 2'b10 && tick);
	miss_c: cover property (REG_RD && !hit);

endmodule

// ==== igc_pkg.sv ====
// Constants, types and helpers for the input gain control register bank.
// Assumes a single core clock at 10 MHz and a synchronous active-high reset.
//
// Functional notes
// (R1) Amp 3 bit 7 low keeps input three as a line input with the amp off, high powers the amp up as a mic input with gain slewing.
// (R2) Amp 3 bit 6 mutes the amp, resets to one, and while it is set the gain code is ignored.
// (R3) The 6-bit gain code runs from -12 dB at zero in 0.75 dB steps to +35.25 dB at all ones.
// (R4) The amp 3 control register sits at 0x26 and resets to 0x40, muted, off and gain code zero.
// (R5) Slew register bits 5:4 pick the gain change time of 21.5 ms, 42.5 ms or 85 ms.
// (R6) Slew register bits 3:0 turn off slewing for amps 3 to 0, which then ignore the slew time.
// (R7) The slew register sits at 0x27 and resets to 0x00, slewing on everywhere at the shortest time.
// (R8) Boost register bits 3:0 at 0x28, reset zero, add 10 dB to amps 3 to 0.
// (R9) Bits 5:4 of the charge register at 0x29 turn off click guarding on headphones 1 and 0; reset is 0x3f.
// (R10) Bits 3:0 of the charge register turn off click guarding on the inputs of amps 3 to 0.
// (R11) Amps 0 to 2 have the same control layout and reset at 0x23, 0x24 and 0x25.
// (R12) Software writes zero to reserved bits and avoids slew code 11; reserved bits hold zero.

////////////////////////////////////////////////////////////////////////////////
package igc_pkg;

	localparam int NUM_AMPS = 4;

	// Register addresses
	localparam logic [7:0] ADDR_AMP0 = 8'h23;
	localparam logic [7:0] ADDR_AMP3 = 8'h26;
	localparam logic [7:0] ADDR_SLEW = 8'h27;
	localparam logic [7:0] ADDR_BOOST = 8'h28;
	localparam logic [7:0] ADDR_POP = 8'h29;

	// Reset values
	localparam logic [7:0] RST_AMP = 8'h40;
	localparam logic [7:0] RST_SLEW = 8'h00;
	localparam logic [7:0] RST_BOOST = 8'h00;
	localparam logic [7:0] RST_POP = 8'h3f;

	// Writable bits; reserved bits stay zero
	localparam logic [7:0] MASK_AMP = 8'hff;
	localparam logic [7:0] MASK_SLEW = 8'h3f;
	localparam logic [7:0] MASK_BOOST = 8'h0f;
	localparam logic [7:0] MASK_POP = 8'h3f;

	// Field positions
	localparam int AMP_SEL_BIT = 7;
	localparam int AMP_MUTE_BIT = 6;
	localparam int GAIN_LSB = 0;
	localparam int GAIN_W = 6;
	localparam int RATE_LSB = 4;
	localparam int RATE_W = 2;
	localparam int HP_GUARD_LSB = 4;

	// Gain in quarter dB
	localparam int QDB_BASE = -48;
	localparam int QDB_STEP = 3;
	localparam int BOOST_QDB = 40;

	// Slew timing
	localparam int CLK_NS = 100;
	localparam int SLEW0_US = 21500;
	localparam int SLEW1_US = 42500;
	localparam int SLEW2_US = 85000;
	localparam int GAIN_STEPS = 63;
	localparam int STEP_CYC0 = SLEW0_US * 1000 / CLK_NS / GAIN_STEPS;
	localparam int STEP_CYC1 = SLEW1_US * 1000 / CLK_NS / GAIN_STEPS;
	localparam int STEP_CYC2 = SLEW2_US * 1000 / CLK_NS / GAIN_STEPS;
	localparam int TMR_W = 16;

	typedef enum logic [1:0] {
		IGC_OFF = 2'b00,
		IGC_RAMP = 2'b01,
		IGC_HOLD = 2'b11
	} igc_ramp_e;

	// Gain code plus boost to quarter dB
	function automatic logic signed [8:0] gain_qdb(
		logic [5:0] code,
		logic boost
	);
		int v;
		v = QDB_BASE + QDB_STEP * int'(code) + (boost ? BOOST_QDB : 0); // R3 R8
		return 9'(v);
	endfunction

endpackage

// ==== igc_step_timer.sv ====
// Step tick generator shared by all gain ramps.
// Assumes the slew code is a static register field.

////////////////////////////////////////////////////////////////////////////////
module igc_step_timer #(
	parameter int CYC0 = igc_pkg::STEP_CYC0,
	parameter int CYC1 = igc_pkg::STEP_CYC1,
	parameter int CYC2 = igc_pkg::STEP_CYC2
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Control
	input wire logic [1:0] rate,
	// Tick
	output logic tick
);

	typedef struct packed {
		logic [igc_pkg::TMR_W-1:0] cnt;
		logic [1:0] rate;
		logic tick;
	} igc_tmr_s;

	igc_tmr_s r, n;
	logic [igc_pkg::TMR_W-1:0] reload;

	// Code 11 is undefined; treated as the longest time
	always_comb begin
		if (rate == 2'b00) begin
			reload = igc_pkg::TMR_W'(CYC0 - 1); // R5
		end else if (rate == 2'b01) begin
			reload = igc_pkg::TMR_W'(CYC1 - 1); // R5
		end else begin
			reload = igc_pkg::TMR_W'(CYC2 - 1); // R5
		end
	end

	always_comb begin
		n = r;
		n.rate = rate;
		n.tick = 1'b0;
		if (rate != r.rate || r.cnt == '0) begin
			n.cnt = reload;
			n.tick = (rate == r.rate);
		end else begin
			n.cnt = r.cnt - 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign tick = r.tick;

endmodule

// ==== igc_gain_ramp.sv ====
// Gain ramp for one amplifier: power, mute and applied gain code.
// Assumes a one-cycle step tick from the shared timer.

////////////////////////////////////////////////////////////////////////////////
module igc_gain_ramp (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Control fields
	input wire logic mic_sel,
	input wire logic mute,
	input wire logic [5:0] code,
	input wire logic boost,
	input wire logic slew_off,
	input wire logic tick,
	// Amplifier drive
	output logic power,
	output logic muted,
	output logic ramping,
	output logic [5:0] gain,
	output logic signed [8:0] gain_qdb
);

	typedef struct packed {
		igc_pkg::igc_ramp_e st;
		logic [5:0] cur;
		logic mute;
		logic signed [8:0] qdb;
	} igc_ramp_s;

	igc_ramp_s r, n;
	logic [5:0] target;

	// Muted: gain code ignored, gain frozen
	assign target = mute ? r.cur : code; // R2

	always_comb begin
		n = r;
		n.mute = mute; // R2
		case (r.st)
			igc_pkg::IGC_OFF: begin
				n.cur = '0;
				if (mic_sel) begin
					n.st = igc_pkg::IGC_RAMP; // R1
				end
			end
			default: begin
				if (!mic_sel) begin
					n.st = igc_pkg::IGC_OFF; // R1
					n.cur = '0;
				end else if (slew_off) begin
					n.st = igc_pkg::IGC_HOLD; // R6
					n.cur = target;
				end else if (r.cur == target) begin
					n.st = igc_pkg::IGC_HOLD;
				end else begin
					n.st = igc_pkg::IGC_RAMP;
					if (tick) begin
						n.cur = (r.cur < target) ? r.cur + 1'b1 : r.cur - 1'b1;
					end
				end
			end
		endcase
		n.qdb = igc_pkg::gain_qdb(n.cur, boost); // R3 R8
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			// Applied gain reads as code zero from the first cycle
			r <= {igc_pkg::IGC_OFF, 6'h00, 1'b1, 9'(igc_pkg::QDB_BASE)}; // R3
		end else begin
			r <= n;
		end
	end

	assign power = (r.st != igc_pkg::IGC_OFF);
	assign muted = r.mute;
	assign ramping = (r.st == igc_pkg::IGC_RAMP);
	assign gain = r.cur;
	assign gain_qdb = r.qdb;

endmodule

// ==== input_gain_control_regs_tb_top.sv ====
// Self-checking bench for the input gain control register bank.
// Assumes the strobe register port and shortened step counts 4, 5, 6.

////////////////////////////////////////////////////////////////////////////////
module input_gain_control_regs_tb_top;
	timeunit 1ns;
	timeprecision 1ns;

	logic SYS_CLK = 1'b0;
	logic RST = 1'b1;
	logic [7:0] REG_ADDR = 8'h00;
	logic REG_WR = 1'b0;
	logic REG_RD = 1'b0;
	logic [7:0] REG_WDATA = 8'h00;
	logic [7:0] REG_RDATA;
	logic REG_ACK;
	logic [3:0] AMP_POWER_UP, AMP_MUTE, AMP_RAMPING, AMP_EXTRA_GAIN;
	logic [3:0][5:0] AMP_GAIN_CODE;
	logic [3:0][8:0] AMP_GAIN_QDB;
	logic [3:0] AMP_CLICK_GUARD_OFF;
	logic HEADPHONE0_CLICK_GUARD_OFF, HEADPHONE1_CLICK_GUARD_OFF;
	int n_mismatch = 0;
	int checks_done = 0;
	integer seed = 48;
	logic [7:0] sh [8];
	logic [7:0] d;
	int i, n;

	igc_regs #(.STEP_CYC0(4), .STEP_CYC1(5), .STEP_CYC2(6)) dut (
		.SYS_CLK(SYS_CLK), .RST(RST), .REG_ADDR(REG_ADDR),
		.REG_WR(REG_WR), .REG_RD(REG_RD), .REG_WDATA(REG_WDATA),
		.REG_RDATA(REG_RDATA), .REG_ACK(REG_ACK),
		.AMP_POWER_UP(AMP_POWER_UP), .AMP_MUTE(AMP_MUTE),
		.AMP_RAMPING(AMP_RAMPING), .AMP_EXTRA_GAIN(AMP_EXTRA_GAIN),
		.AMP_GAIN_CODE(AMP_GAIN_CODE), .AMP_GAIN_QDB(AMP_GAIN_QDB),
		.AMP_CLICK_GUARD_OFF(AMP_CLICK_GUARD_OFF),
		.HEADPHONE0_CLICK_GUARD_OFF(HEADPHONE0_CLICK_GUARD_OFF),
		.HEADPHONE1_CLICK_GUARD_OFF(HEADPHONE1_CLICK_GUARD_OFF)
	);

	always #50 SYS_CLK = ~SYS_CLK;

	////////////////////////////////////////////////////////////////////////
	// Expectations
	function automatic logic [7:0] rval(input int k);
		return (k < 4) ? 8'h40 : (k == 6) ? 8'h3f : 8'h00;
	endfunction

	function automatic logic [7:0] rmask(input int k);
		return (k < 4) ? 8'hff : (k == 5) ? 8'h0f : (k == 7) ? 8'h00 : 8'h3f;
	endfunction

	function automatic logic [8:0] exp_qdb(input int code, input logic b);
		int v;
		v = -48 + 3 * code + (b ? 40 : 0);
		return v[8:0];
	endfunction

	function automatic int cyc(input int r);
		return 4 + r;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Checking and register port
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic complete_run;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// One idle cycle between requests keeps strobes single-assigned
	task automatic reg_op(input logic w, input logic [7:0] a,
		input logic [7:0] wd, output logic [7:0] rd);
		logic m;
		m = (a >= 8'h23 && a <= 8'h29);
		@(negedge SYS_CLK);
		REG_ADDR = a;
		REG_WDATA = wd;
		REG_WR = w;
		REG_RD = ~w;
		@(negedge SYS_CLK);
		REG_WR = 1'b0;
		REG_RD = 1'b0;
		rd = REG_RDATA;
		check(16'(REG_ACK), 16'(m));
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] wd);
		logic [7:0] rd;
		reg_op(1'b1, a, wd, rd);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] rd;
		reg_op(1'b0, a, 8'h00, rd);
		check(16'(rd), 16'(exp));
	endtask

	task automatic do_reset;
		@(negedge SYS_CLK);
		RST = 1'b1;
		repeat (4) @(negedge SYS_CLK);
		RST = 1'b0;
	endtask

	task automatic reset_check;
		for (int k = 0; k < 7; k++) begin
			rd_chk(8'h23 + 8'(k), rval(k));
			sh[k] = rval(k);
		end
		rd_chk(8'h22, 8'h00);
		rd_chk(8'h2a, 8'h00);
		check(16'(AMP_MUTE), 16'hf);
		check(16'(AMP_POWER_UP), 16'h0);
		check(16'(AMP_EXTRA_GAIN), 16'h0);
		check(16'({HEADPHONE1_CLICK_GUARD_OFF, HEADPHONE0_CLICK_GUARD_OFF,
			AMP_CLICK_GUARD_OFF}), 16'h3f);
		for (int k = 0; k < 4; k++)
			check(16'(AMP_GAIN_QDB[k]), 16'(exp_qdb(0, 0)));
	endtask

	// Bounded wait for one amp to reach its target and stop slewing
	task automatic settle(input int k, input logic [5:0] tgt, output int c);
		c = 0;
		while ((AMP_GAIN_CODE[k] !== tgt || AMP_RAMPING[k] !== 1'b0)
			&& c < 2000) begin
			@(negedge SYS_CLK);
			c++;
		end
		check(16'(AMP_GAIN_CODE[k]), 16'(tgt));
		check(16'(AMP_RAMPING[k]), 16'h0);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Scenarios
	initial begin
		repeat (4) @(negedge SYS_CLK);
		RST = 1'b0;
		reset_check();
		// Random traffic, slot 7 stands for an unmapped address
		repeat (30) begin
			i = $unsigned($random(seed)) % 8;
			d = 8'($random(seed));
			if (i == 4 && d[5:4] == 2'b11)
				d[5] = 1'b0;
			wr(8'h23 + 8'(i), d);
			if (i < 7)
				sh[i] = d & rmask(i);
			rd_chk(8'h23 + 8'(i), (i < 7) ? sh[i] : 8'h00);
			check(16'(AMP_EXTRA_GAIN), 16'(sh[5][3:0]));
			check(16'({HEADPHONE1_CLICK_GUARD_OFF, HEADPHONE0_CLICK_GUARD_OFF,
				AMP_CLICK_GUARD_OFF}), 16'(sh[6][5:0]));
		end
		do_reset();
		reset_check();
		// Ramp time follows the slew code
		for (int r = 0; r < 3; r++) begin
			wr(8'h27, 8'(r << 4));
			wr(8'h26, 8'h00);
			settle(3, 6'd0, n);
			wr(8'h26, 8'h88);
			@(negedge SYS_CLK);
			check(16'(AMP_RAMPING[3]), 16'h1);
			settle(3, 6'd8, n);
			check(16'(n >= 7 * cyc(r) - 2 && n <= 8 * cyc(r) + 4), 16'h1);
			check(16'(AMP_POWER_UP[3]), 16'h1);
			check(16'(AMP_GAIN_QDB[3]), 16'(exp_qdb(8, 0)));
		end
		// Mute freezes the applied gain
		wr(8'h26, 8'he0);
		repeat (40) @(negedge SYS_CLK);
		check(16'(AMP_GAIN_CODE[3]), 16'd8);
		check(16'(AMP_MUTE[3]), 16'h1);
		// Slew off jumps straight to the top code
		wr(8'h27, 8'h08);
		wr(8'h26, 8'hbf);
		repeat (2) @(negedge SYS_CLK);
		check(16'(AMP_GAIN_CODE[3]), 16'd63);
		check(16'(AMP_GAIN_QDB[3]), 16'(exp_qdb(63, 0)));
		wr(8'h28, 8'h08);
		repeat (2) @(negedge SYS_CLK);
		check(16'(AMP_GAIN_QDB[3]), 16'(exp_qdb(63, 1)));
		wr(8'h26, 8'h80);
		repeat (2) @(negedge SYS_CLK);
		check(16'(AMP_GAIN_QDB[3]), 16'(exp_qdb(0, 1)));
		wr(8'h26, 8'h3f);
		repeat (2) @(negedge SYS_CLK);
		check(16'(AMP_POWER_UP[3]), 16'h0);
		check(16'(AMP_GAIN_CODE[3]), 16'd0);
		// Per-amp slew disables on the lower amps
		for (int k = 0; k < 3; k++) begin
			wr(8'h27, 8'(1 << k));
			wr(8'h23 + 8'(k), 8'hbf);
			repeat (2) @(negedge SYS_CLK);
			check(16'(AMP_GAIN_CODE[k]), 16'd63);
		end
		// Code 0x10 is the 0 dB point
		wr(8'h27, 8'h02);
		wr(8'h24, 8'h90);
		repeat (2) @(negedge SYS_CLK);
		check(16'(AMP_GAIN_CODE[1]), 16'd16);
		check(16'(AMP_GAIN_QDB[1]), 16'(exp_qdb(16, 0)));
		complete_run();
	end

	initial begin
		#3000000;
		n_mismatch++;
		complete_run();
	end
endmodule
